// file: hw/cfg_status_bank.sv
// configuration status flags, operational window base and power capability word
`timescale 1ns/10ps
`default_nettype none
module cfg_status_bank
    import cfg_status_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire cfg_req_type CFG_REQ,
    input wire status_event_type STATUS_EVENTS,
    input wire logic PARITY_RESP_EN,
    input wire logic ID_OVERRIDE_PERMIT,
    input wire logic ROM_PRESENT,
    input wire logic SROM_SDA_IN,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    output logic CFG_READY,
    output logic [BASE_W-1:0] OP_WINDOW_BASE,
    output logic SROM_SCL,
    output logic SROM_SDA_OUT,
    output logic SROM_SDA_OE
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction : hit

    logic busy;
    logic load;
    loaded_caps_type caps;
    logic take_rd, take_wr;
    logic [N_FLAGS-1:0] flag_set, flag_clr, flag;
    logic [15:0] status_word, power_word;
    logic [BASE_W-1:0] base_q, base_d;
    logic [2:0] aux_q, aux_d;
    logic cold_q, cold_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic ready_q, ready_d;
    logic [31:0] base_word;

    rom_loader u_loader (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .rom_present(ROM_PRESENT),
        .sda_in(SROM_SDA_IN),
        .scl(SROM_SCL),
        .sda_out(SROM_SDA_OUT),
        .sda_oe(SROM_SDA_OE),
        .busy(busy),
        .load(load),
        .caps(caps)
    );

    assign take_rd = CFG_REQ.rd & ~busy;
    assign take_wr = CFG_REQ.wr & ~busy;

    assign flag_set = {
        STATUS_EVENTS.det_parity_error,
        STATUS_EVENTS.sig_system_error,
        STATUS_EVENTS.rcv_master_abort,
        STATUS_EVENTS.rcv_target_abort,
        STATUS_EVENTS.sig_target_abort,
        STATUS_EVENTS.perr_as_master & PARITY_RESP_EN
    };

    genvar gi;
    generate
        for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
            // all error bits live in the top byte lane
            assign flag_clr[gi] = take_wr & hit(CFG_REQ.addr, OFS_STATUS) & CFG_REQ.be[3]
                & CFG_REQ.wdata[HALF_LSB + int'(FLAG_BIT[gi])];
            sticky_flag u_flag (
                .clk(CLK_SYS),
                .rst_n(RESET_N),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .q(flag[gi])
            );
        end
    endgenerate

    always_comb begin
        status_word = 16'h0000;
        status_word[DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
        for (int i = 0; i < N_FLAGS; i++) begin
            status_word[FLAG_BIT[i]] = flag[i];
        end
    end

    assign base_word = {base_q, BASE_RO_BITS[BASE_LSB-1:0]};

    always_comb begin
        power_word = 16'h0000;
        power_word[2:0] = PWR_VERSION;
        power_word[5:3] = PWR_FIXED_5_3;
        power_word[AUX_LSB +: 3] = cold_q ? aux_q : 3'h0;
        power_word[SLEEP_LSB +: 2] = SLEEP_SUPPORT;
        power_word[WAKE_LSB +: 4] = WAKE_STATE_MASK;
        power_word[COLD_BIT] = cold_q;
    end

    always_comb begin
        base_d = base_q;
        aux_d = aux_q;
        cold_d = cold_q;
        if (take_wr && hit(CFG_REQ.addr, OFS_BASE)) begin
            if (CFG_REQ.be[1]) begin
                base_d[3:0] = CFG_REQ.wdata[15:12];
            end
            if (CFG_REQ.be[2]) begin
                base_d[11:4] = CFG_REQ.wdata[23:16];
            end
            if (CFG_REQ.be[3]) begin
                base_d[19:12] = CFG_REQ.wdata[31:24];
            end
        end
        if (take_wr && hit(CFG_REQ.addr, OFS_POWER) && ID_OVERRIDE_PERMIT) begin
            if (CFG_REQ.be[2]) begin
                aux_d[1:0] = CFG_REQ.wdata[HALF_LSB + AUX_LSB +: 2];
            end
            if (CFG_REQ.be[3]) begin
                aux_d[2] = CFG_REQ.wdata[HALF_LSB + AUX_LSB + 2];
                cold_d = CFG_REQ.wdata[HALF_LSB + COLD_BIT];
            end
        end
        if (load) begin
            aux_d = caps.aux_current;
            cold_d = caps.cold_wake;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        ack_d = take_rd | take_wr;
        ready_d = ~busy;
        if (take_rd) begin
            // unmapped dwords and the out-of-bank low halves read zero
            rdata_d = 32'h0000_0000;
            if (hit(CFG_REQ.addr, OFS_STATUS)) begin
                rdata_d = {status_word, 16'h0000};
            end else if (hit(CFG_REQ.addr, OFS_BASE)) begin
                rdata_d = base_word;
            end else if (hit(CFG_REQ.addr, OFS_POWER)) begin
                rdata_d = {power_word, 16'h0000};
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            base_q <= 20'h0_0000;
            aux_q <= AUX_RESET;
            cold_q <= COLD_RESET;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            base_q <= base_d;
            aux_q <= aux_d;
            cold_q <= cold_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            ready_q <= ready_d;
        end
    end

    assign CFG_RDATA = rdata_q;
    assign CFG_ACK = ack_q;
    assign CFG_READY = ready_q;
    assign OP_WINDOW_BASE = base_q;

    AST_PERR_SET: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS_EVENTS.perr_as_master && PARITY_RESP_EN |=> flag[0])
        else $error("master parity flag not set");

    AST_PERR_GATED: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !flag[0] && !PARITY_RESP_EN |=> !flag[0])
        else $error("master parity flag set while response disabled");

    AST_DEVSEL_READ: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_rd && hit(CFG_REQ.addr, OFS_STATUS) |=> CFG_ACK && CFG_RDATA[26:25] == 2'h1)
        else $error("select timing field wrong");

    AST_ABORT_FLAGS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS_EVENTS.sig_target_abort || STATUS_EVENTS.rcv_target_abort
        || STATUS_EVENTS.rcv_master_abort || STATUS_EVENTS.sig_system_error
        |=> (flag[4:1] | ~$past({STATUS_EVENTS.sig_system_error, STATUS_EVENTS.rcv_master_abort,
            STATUS_EVENTS.rcv_target_abort, STATUS_EVENTS.sig_target_abort})) == 4'hF)
        else $error("abort or system error flag not set");

    AST_PARITY_ANY: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS_EVENTS.det_parity_error |=> flag[5] ##1 (flag[5] || $past(flag_clr[5])))
        else $error("detected parity flag not set");

    AST_W1C_ZERO_KEEPS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        flag[4] && take_wr && hit(CFG_REQ.addr, OFS_STATUS) && !CFG_REQ.wdata[30] |=> flag[4])
        else $error("zero write cleared a flag");

    AST_W1C_ONE_CLEARS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_wr && hit(CFG_REQ.addr, OFS_STATUS) && CFG_REQ.be[3] && CFG_REQ.wdata[28]
        && !STATUS_EVENTS.rcv_target_abort |=> !flag[2])
        else $error("one write did not clear flag");

    AST_BASE_LOW_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_rd && hit(CFG_REQ.addr, OFS_BASE) |=> CFG_RDATA[11:0] == 12'h000)
        else $error("base low bits not zero");

    AST_BASE_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_wr && hit(CFG_REQ.addr, OFS_BASE) && CFG_REQ.be == 4'hF
        |=> OP_WINDOW_BASE == $past(CFG_REQ.wdata[31:12]) && !load)
        else $error("base did not take write");

    AST_POWER_FIXED: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_rd && hit(CFG_REQ.addr, OFS_POWER)
        |=> CFG_RDATA[21:16] == 6'h02 && CFG_RDATA[30:25] == 6'h3F)
        else $error("fixed capability bits wrong");

    AST_AUX_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_rd && hit(CFG_REQ.addr, OFS_POWER) && !cold_q
        |=> CFG_RDATA[24:22] == 3'h0 && !CFG_RDATA[31])
        else $error("aux current not zero without cold wake");

    AST_LOCKED_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        take_wr && hit(CFG_REQ.addr, OFS_POWER) && !ID_OVERRIDE_PERMIT && !load
        |=> $stable(aux_q) && $stable(cold_q))
        else $error("locked capability field changed");

    AST_BUSY_REFUSE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        busy |=> !CFG_ACK && !CFG_READY)
        else $error("access taken during rom load");

endmodule : cfg_status_bank
`default_nettype wire

// file: hw/cfg_status_pkg.sv
// shared constants and types for the configuration status, base and power capability bank
package cfg_status_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS = 5000;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SCL_HALF_LAST = 10'(SCL_HALF_CYC - 1);

    // configuration dword byte addresses
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BASE = 8'h10;
    localparam logic [7:0] OFS_POWER = 8'h40;

    // status word layout (bits of the 16-bit status half)
    localparam int N_FLAGS = 6;
    localparam logic [N_FLAGS-1:0][3:0] FLAG_BIT = {4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h8};
    localparam int DEVSEL_LSB = 9;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam int HALF_LSB = 16;

    // base address layout
    localparam int BASE_LSB = 12;
    localparam int BASE_W = 20;
    localparam logic [31:0] BASE_RO_BITS = 32'h0000_0000;

    // power capability layout (bits of the 16-bit capability half)
    localparam logic [2:0] PWR_VERSION = 3'h2;
    localparam logic [2:0] PWR_FIXED_5_3 = 3'h0;
    localparam int AUX_LSB = 6;
    localparam int SLEEP_LSB = 9;
    localparam logic [1:0] SLEEP_SUPPORT = 2'h3;
    localparam int WAKE_LSB = 11;
    localparam logic [3:0] WAKE_STATE_MASK = 4'hF;
    localparam int COLD_BIT = 15;
    localparam logic [2:0] AUX_RESET = 3'h0;
    localparam logic COLD_RESET = 1'b0;

    // serial rom: control byte of a current-address read, byte layout of loaded value
    localparam logic [7:0] ROM_READ_CTRL = 8'hA1;
    localparam int ROM_COLD_BIT = 7;

    typedef struct packed {
        logic det_parity_error;
        logic sig_system_error;
        logic rcv_master_abort;
        logic rcv_target_abort;
        logic sig_target_abort;
        logic perr_as_master;
    } status_event_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_type;

    typedef struct packed {
        logic cold_wake;
        logic [2:0] aux_current;
    } loaded_caps_type;

endpackage : cfg_status_pkg

// file: hw/sticky_flag.sv
// one hardware-set, write-one-to-clear status flag
`timescale 1ns/10ps
`default_nettype none
module sticky_flag
    import cfg_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        // a set in the clearing cycle wins
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
        set |=> flag_q)
        else $error("flag lost a set event");

endmodule : sticky_flag
`default_nettype wire

// file: hw/rom_loader.sv
// two-wire serial rom reader that fetches the loader-writable capability fields
`timescale 1ns/10ps
`default_nettype none
module rom_loader
    import cfg_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rom_present,
    input wire logic sda_in,
    output logic scl,
    output logic sda_out,
    output logic sda_oe,
    output logic busy,
    output logic load,
    output loaded_caps_type caps
);
    typedef enum logic [2:0] {
        L_IDLE, L_START, L_ADDR, L_AACK, L_DATA, L_NACK, L_STOP, L_DONE
    } ld_state_type;

    ld_state_type st_q, st_d;
    logic [9:0] div_q, div_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic scl_q, scl_d, oe_q, oe_d, busy_q, busy_d, load_q, load_d, ok_q, ok_d;
    logic tick;

    assign tick = (div_q == SCL_HALF_LAST);

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        scl_d = scl_q;
        oe_d = oe_q;
        busy_d = busy_q;
        load_d = 1'b0;
        ok_d = ok_q;
        div_d = tick ? 10'h000 : 10'(div_q + 10'h001);
        unique case (st_q)
            L_IDLE: begin
                if (rom_present) begin
                    oe_d = 1'b1;
                    st_d = L_START;
                end else begin
                    busy_d = 1'b0;
                    st_d = L_DONE;
                end
            end
            L_START: if (tick) begin
                scl_d = 1'b0;
                oe_d = ~ROM_READ_CTRL[7];
                bit_d = 3'h7;
                st_d = L_ADDR;
            end
            L_ADDR: if (tick) begin
                scl_d = ~scl_q;
                if (scl_q) begin
                    if (bit_q == 3'h0) begin
                        oe_d = 1'b0;
                        st_d = L_AACK;
                    end else begin
                        bit_d = 3'(bit_q - 3'h1);
                        oe_d = ~ROM_READ_CTRL[3'(bit_q - 3'h1)];
                    end
                end
            end
            L_AACK: if (tick) begin
                scl_d = ~scl_q;
                if (scl_q) begin
                    ok_d = ~sda_in;
                    bit_d = 3'h7;
                    oe_d = sda_in;
                    st_d = sda_in ? L_STOP : L_DATA;
                end
            end
            L_DATA: if (tick) begin
                scl_d = ~scl_q;
                if (scl_q) begin
                    sh_d = {sh_q[6:0], sda_in};
                    if (bit_q == 3'h0) begin
                        st_d = L_NACK;
                    end else begin
                        bit_d = 3'(bit_q - 3'h1);
                    end
                end
            end
            L_NACK: if (tick) begin
                scl_d = ~scl_q;
                if (scl_q) begin
                    oe_d = 1'b1;
                    st_d = L_STOP;
                end
            end
            L_STOP: if (tick) begin
                if (!scl_q) begin
                    scl_d = 1'b1;
                end else begin
                    oe_d = 1'b0;
                    busy_d = 1'b0;
                    load_d = ok_q;
                    st_d = L_DONE;
                end
            end
            L_DONE: begin
                st_d = L_DONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= L_IDLE;
            div_q <= 10'h000;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            busy_q <= 1'b1;
            load_q <= 1'b0;
            ok_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            scl_q <= scl_d;
            oe_q <= oe_d;
            busy_q <= busy_d;
            load_q <= load_d;
            ok_q <= ok_d;
        end
    end

    assign scl = scl_q;
    assign sda_oe = oe_q;
    assign sda_out = 1'b0;
    assign busy = busy_q;
    assign load = load_q;
    assign caps = '{cold_wake: sh_q[ROM_COLD_BIT], aux_current: sh_q[2:0]};

endmodule : rom_loader
`default_nettype wire

// file: bench/cfg_host.sv
// configuration host model issuing single-cycle requests at the falling edge
`timescale 1ns/10ps
`default_nettype none
module cfg_host
    import cfg_status_pkg::*;
(
    input wire logic clk,
    output var cfg_req_type req
);
    initial begin
        req = '0;
    end

    task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
                          input logic [3:0] be, input logic [31:0] wdata);
        @(negedge clk);
        req <= '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
    endtask : access

    // released lines show the inverse of the last value
    task automatic idle();
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, be: ~req.be, wdata: ~req.wdata};
    endtask : idle
endmodule : cfg_host
`default_nettype wire

// file: bench/test_cfg_status_bank.sv
// self-checking bench for the status, window base and power capability bank
`timescale 1ns/10ps
`default_nettype none
module test_cfg_status_bank;
    import cfg_status_pkg::*;
    logic clk_sys;
    logic reset_n;
    cfg_req_type cfg_req;
    status_event_type events;
    logic parity_resp_en;
    logic permit;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    logic cfg_ready;
    logic [BASE_W-1:0] op_base;
    logic [32:0] notes[$];
    logic [15:0] st_m;
    logic [19:0] base_m;
    logic [2:0] aux_m;
    logic cold_m;
    logic [31:0] seed;
    logic [31:0] d;
    logic [31:0] b;
    logic rom_present;
    logic rom_pull;
    logic [7:0] rom_byte;
    logic [7:0] ctrl_seen;
    logic srom_scl;
    logic srom_oe;
    logic sda_line;
    int falls;
    int n_errors;
    int samples_checked;

    cfg_status_bank cfg_status_bank_inst (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .CFG_REQ(cfg_req), .STATUS_EVENTS(events),
        .PARITY_RESP_EN(parity_resp_en), .ID_OVERRIDE_PERMIT(permit),
        .ROM_PRESENT(rom_present), .SROM_SDA_IN(sda_line),
        .CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack), .CFG_READY(cfg_ready),
        .OP_WINDOW_BASE(op_base), .SROM_SCL(srom_scl), .SROM_SDA_OUT(),
        .SROM_SDA_OE(srom_oe)
    );

    // serial rom: acks the control byte, then shifts out rom_byte msb first
    assign sda_line = ~(srom_oe | rom_pull);
    always @(negedge srom_scl or negedge reset_n) begin
        if (!reset_n) begin
            falls = 0;
            rom_pull = 1'b0;
        end else begin
            falls++;
            rom_pull = (falls == 9) || (falls >= 10 && falls <= 17 && !rom_byte[17 - falls]);
        end
    end
    always @(posedge srom_scl) begin
        if (falls >= 1 && falls <= 8) ctrl_seen = {ctrl_seen[6:0], sda_line};
    end
    cfg_host cfg_host_inst (.clk(clk_sys), .req(cfg_req));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] cap_exp();
        return {cold_m, 4'hF, 2'h3, (cold_m ? aux_m : 3'h0), 3'h0, 3'h2, 16'h0000};
    endfunction : cap_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checked %0d values, %0d errors", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        cfg_host_inst.access(1'b1, 1'b0, addr, 4'h0, rnd());
        notes.push_back({1'b1, exp});
    endtask : rd

    task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
        cfg_host_inst.access(1'b0, 1'b1, addr, be, data);
        notes.push_back({1'b0, 32'h0000_0000});
    endtask : wr

    task automatic pulse(input int i, input logic en);
        @(negedge clk_sys);
        events <= status_event_type'(6'h01 << i);
        parity_resp_en <= en;
        @(negedge clk_sys);
        events <= '0;
        if (i != 0 || en) st_m[FLAG_BIT[i]] = 1'b1;
    endtask : pulse

    task automatic do_reset(input logic rom);
        @(negedge clk_sys);
        reset_n <= 1'b0;
        rom_present <= rom;
        d = rnd();
        rom_byte = d[7:0] | 8'h80;
        repeat (20) @(negedge clk_sys);
        reset_n <= 1'b1;
        st_m = 16'h0200;
        base_m = '0;
        aux_m = rom ? rom_byte[2:0] : AUX_RESET;
        cold_m = rom ? rom_byte[ROM_COLD_BIT] : COLD_RESET;
        if (rom) begin
            repeat (4) @(negedge clk_sys);
            check({31'h0, cfg_ready}, 32'h0);
            // refused while loading: no note, so any answer is a mismatch
            cfg_host_inst.access(1'b1, 1'b0, OFS_STATUS, 4'h0, 32'h0000_0000);
            cfg_host_inst.idle();
        end
        for (int c = 0; c < 30000 && cfg_ready !== 1'b1; c++) @(negedge clk_sys);
        check({31'h0, cfg_ready}, 32'h1);
        if (rom) check({24'h0, ctrl_seen}, {24'h0, ROM_READ_CTRL});
        rd(OFS_STATUS, {st_m, 16'h0000});
        rd(OFS_BASE, 32'h0000_0000);
        rd(OFS_POWER, cap_exp());
        cfg_host_inst.idle();
    endtask : do_reset

    // takes the oldest note whenever an answer shows
    always @(negedge clk_sys) begin
        if (cfg_ack === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else if (notes[0][32]) begin
                check(cfg_rdata, notes[0][31:0]);
                void'(notes.pop_front());
            end else begin
                void'(notes.pop_front());
            end
        end
    end

    initial begin
        #500_000;
        n_errors++;
        results();
    end

    initial begin
        reset_n = 1'b0;
        events = '0;
        parity_resp_en = 1'b0;
        permit = 1'b0;
        seed = 32'd81498;
        n_errors = 0;
        samples_checked = 0;
        rom_present = 1'b0;
        ctrl_seen = 8'h00;
        do_reset(1'b0);
        // each event, with and without parity response; zero write keeps, one clears
        for (int i = 0; i < N_FLAGS; i++) begin
            for (int en = 0; en < 2; en++) begin
                pulse(i, en[0]);
                rd(OFS_STATUS, {st_m, 16'h0000});
                wr(OFS_STATUS, 4'hF, 32'h0000_0000);
                rd(OFS_STATUS, {st_m, 16'h0000});
                wr(OFS_STATUS, 4'hF, 32'hFFFF_FFFF);
                st_m = st_m & ~16'hF900;
                rd(OFS_STATUS, {st_m, 16'h0000});
                cfg_host_inst.idle();
            end
        end
        // set wins over a clear in the same cycle
        fork
            begin
                wr(OFS_STATUS, 4'hF, 32'hFFFF_FFFF);
                cfg_host_inst.idle();
            end
            pulse(5, 1'b0);
        join
        rd(OFS_STATUS, {st_m, 16'h0000});
        cfg_host_inst.idle();
        // window base: sizing write then random lanes
        wr(OFS_BASE, 4'hF, 32'hFFFF_FFFF);
        base_m = 20'hF_FFFF;
        rd(OFS_BASE, 32'hFFFF_F000);
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            b = rnd();
            wr(OFS_BASE, b[3:0], d);
            if (b[1]) base_m[3:0] = d[15:12];
            if (b[2]) base_m[11:4] = d[23:16];
            if (b[3]) base_m[19:12] = d[31:24];
            rd(OFS_BASE, {base_m, 12'h000});
            cfg_host_inst.idle();
            @(negedge clk_sys);
            check({12'h000, op_base}, {12'h000, base_m});
        end
        // loader fields: every current code with cold wake, then refused and masked
        for (int k = 0; k < 12; k++) begin
            @(negedge clk_sys);
            permit <= (k < 8 || k == 10);
            d = (k < 8) ? (32'h8000_0000 | (32'(k) << 22)) : rnd();
            wr(OFS_POWER, 4'hC, d);
            if (k < 8 || k == 10) begin
                cold_m = d[31];
                aux_m = d[24:22];
            end
            rd(OFS_POWER, cap_exp());
            cfg_host_inst.idle();
        end
        // unmapped places
        wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        rd(8'h08, 32'h0000_0000);
        rd(8'h44, 32'h0000_0000);
        cfg_host_inst.idle();
        // flag set, then reset mid-run with the serial rom fitted
        pulse(3, 1'b1);
        do_reset(1'b1);
        repeat (4) @(negedge clk_sys);
        check(notes.size(), 32'h0);
        results();
    end
endmodule : test_cfg_status_bank
`default_nettype wire
